// [logic/clu_cell.sv]
/*
  Configurable logic unit: four source muxes, four OR gates, eight
  functions, edge interrupts and an Avalon-MM register slave.
  Assumes the 32 source signals may come from any domain; all are
  synchronised before use.
*/
// Decided for this implementation: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module clu_cell
  import clu_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Avalon-MM slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Candidate sources, eight per mux
  input wire logic [31:0] src_in,
  // Cell output, pin and interrupt
  output logic cell_out,
  output logic pin_out,
  output logic pin_oe,
  output logic irq
);
  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  function automatic logic [15:0] merge16(input logic [15:0] old,
      input logic [31:0] wd, input logic [3:0] be);
    logic [15:0] m;
    m = old;
    if (be[0])
    begin
      m[7:0] = wd[7:0];
    end
    if (be[1])
    begin
      m[15:8] = wd[15:8];
    end
    return m;
  endfunction

  function automatic logic src_pick(input logic [31:0] s,
      input logic [15:0] sel, input int k);
    logic [2:0] f;
    f = sel[k*CLU_SEL_STRIDE +: 3];
    return s[k*8 + int'(f)];
  endfunction

  clu_state_t r;
  clu_state_t n;
  logic [3:0] d;
  logic [7:0] terms;
  logic [3:0] g;
  logic [3:0] g_rise;
  logic comb_out;
  logic raw;
  logic acc;
  logic wr;
  logic rd;
  logic [15:0] ctrl_low;
  logic [15:0] ctrl_wr;

  // --------------------------------------------------------------
  // Source muxes and gates
  // --------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_gate
      assign d[gi] = src_pick(r.sync2, r.src_sel, gi); // RL1 RL2
      assign terms[2*gi+1] = d[gi]; // RL3
      assign terms[2*gi] = ~d[gi]; // RL3
      // An empty selection leaves only the polarity bit.
      assign g[gi] = (|(terms & r.gsel[8*gi +: 8])) // RL4 RL5
                     ^ r.gate_inv[gi]; // RL8 RL15
    end
  endgenerate

  assign g_rise = g & ~r.gate_prev;
  assign acc = r.ack && (avs_read || avs_write);
  assign wr = acc && avs_write;
  assign rd = acc && avs_read;

  always_comb
  begin
    ctrl_low = 16'h0000;
    ctrl_low[CLU_BIT_EN] = r.en;
    ctrl_low[CLU_BIT_RISE_IE] = r.rise_ie;
    ctrl_low[CLU_BIT_FALL_IE] = r.fall_ie;
    ctrl_low[CLU_BIT_PIN_DE] = r.pin_de;
    ctrl_low[CLU_BIT_LEVEL] = r.out; // RL18
    ctrl_low[CLU_BIT_OUT_INV] = r.out_inv;
    ctrl_low[2:0] = r.mode;
  end

  // --------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------
  always_comb
  begin
    n = r;
    n.sync1 = src_in;
    n.sync2 = r.sync1;
    n.gate_prev = g;
    ctrl_wr = merge16(ctrl_low, avs_writedata, avs_byteenable);
    // Bus: one wait cycle, then the request is accepted.
    n.ack = (avs_read || avs_write) && !r.ack;
    n.rdata = 32'h0000_0000;
    if (avs_address == CLU_ADDR_CTRL_LOW)
    begin
      n.rdata[15:0] = ctrl_low;
    end
    else if (avs_address == CLU_ADDR_CTRL_HIGH)
    begin
      n.rdata[3:0] = r.gate_inv;
    end
    else if (avs_address == CLU_ADDR_SRC_SEL)
    begin
      n.rdata[15:0] = r.src_sel;
    end
    else if (avs_address == CLU_ADDR_GSEL_LOW)
    begin
      n.rdata[15:0] = r.gsel[15:0];
    end
    else if (avs_address == CLU_ADDR_GSEL_HIGH)
    begin
      n.rdata[15:0] = r.gsel[31:16];
    end
    else if (avs_address == CLU_ADDR_IRQ_STAT)
    begin
      n.rdata[1:0] = r.irq_stat;
    end
    else if (avs_address == CLU_ADDR_IRQ_MASK)
    begin
      n.rdata[1:0] = r.irq_mask;
    end
    if (!n.ack)
    begin
      n.rdata = r.rdata;
    end
    if (wr)
    begin
      if (avs_address == CLU_ADDR_CTRL_LOW)
      begin
        n.en = ctrl_wr[CLU_BIT_EN]; // RL7
        n.rise_ie = ctrl_wr[CLU_BIT_RISE_IE];
        n.fall_ie = ctrl_wr[CLU_BIT_FALL_IE];
        n.pin_de = ctrl_wr[CLU_BIT_PIN_DE];
        n.out_inv = ctrl_wr[CLU_BIT_OUT_INV];
        n.mode = ctrl_wr[2:0];
      end
      else if (avs_address == CLU_ADDR_CTRL_HIGH && avs_byteenable[0])
      begin
        n.gate_inv = avs_writedata[3:0]; // RL8
      end
      else if (avs_address == CLU_ADDR_SRC_SEL)
      begin
        // Bit 3 of each nibble stays zero.
        n.src_sel = merge16(r.src_sel, avs_writedata, avs_byteenable)
                    & 16'h7777;
      end
      else if (avs_address == CLU_ADDR_GSEL_LOW)
      begin
        n.gsel[15:0] = merge16(r.gsel[15:0], avs_writedata,
                               avs_byteenable); // RL6
      end
      else if (avs_address == CLU_ADDR_GSEL_HIGH)
      begin
        n.gsel[31:16] = merge16(r.gsel[31:16], avs_writedata,
                                avs_byteenable); // RL6
      end
      else if (avs_address == CLU_ADDR_IRQ_MASK && avs_byteenable[0])
      begin
        n.irq_mask = avs_writedata[1:0];
      end
    end
    // Function block.
    case (r.mode)
      CLU_M_AND_OR: comb_out = (g[0] & g[1]) | (g[2] & g[3]); // RL9
      CLU_M_OR_XOR: comb_out = (g[0] | g[1]) ^ (g[2] | g[3]); // RL9
      CLU_M_AND4: comb_out = &g; // RL9
      default: comb_out = r.q;
    endcase
    case (r.mode)
      CLU_M_SR:
      begin
        // Set wins over reset when both are active.
        if (g[0] | g[1])
        begin
          n.q = 1'b1; // RL10
        end
        else if (g[2] | g[3])
        begin
          n.q = 1'b0;
        end
      end
      CLU_M_DFF_SR:
      begin
        if (g[2])
        begin
          n.q = 1'b0; // RL10
        end
        else if (g[3])
        begin
          n.q = 1'b1;
        end
        else if (g_rise[0])
        begin
          n.q = g[1];
        end
      end
      CLU_M_DFF2:
      begin
        if (g[2])
        begin
          n.q = 1'b0; // RL11
        end
        else if (g_rise[0])
        begin
          n.q = g[1] ^ g[3];
        end
      end
      CLU_M_JK:
      begin
        if (g[2])
        begin
          n.q = 1'b0; // RL12
        end
        else if (g_rise[0] && (g[1] || g[3]))
        begin
          n.q = g[1] & g[3] ? ~r.q : g[1];
        end
      end
      CLU_M_LATCH:
      begin
        if (g[2])
        begin
          n.q = 1'b0; // RL13
        end
        else if (g[3])
        begin
          n.q = 1'b1;
        end
        else if (g[0])
        begin
          n.q = g[1];
        end
      end
      default: n.q = 1'b0;
    endcase
    if (!r.en)
    begin
      n.q = 1'b0;
    end
    raw = comb_out ^ r.out_inv; // RL8
    // The cell runs on its own from here on, so software never stalls it.
    n.out = r.en & raw; // RL14 RL16
    n.pin_out = n.out & r.pin_de; // RL18
    n.pin_oe = r.pin_de & r.en; // RL18
    // A read clears only the bits it returned; a bit that arrived after
    // the data was captured, or in this very cycle, stays set.
    if (rd && avs_address == CLU_ADDR_IRQ_STAT)
    begin
      n.irq_stat = r.irq_stat & ~r.rdata[1:0];
    end
    if (r.rise_ie && n.out && !r.out)
    begin
      n.irq_stat[CLU_IRQ_RISE] = 1'b1; // RL17
    end
    if (r.fall_ie && !n.out && r.out)
    begin
      n.irq_stat[CLU_IRQ_FALL] = 1'b1; // RL17
    end
    n.irq = |(n.irq_stat & n.irq_mask);
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      r <= '0;
    end
    else
    begin
      r <= n;
    end
  end

  assign avs_readdata = r.rdata;
  assign avs_waitrequest = ~r.ack;
  assign cell_out = r.out;
  assign pin_out = r.pin_out;
  assign pin_oe = r.pin_oe;
  assign irq = r.irq;

  // --------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  chk_mux_route: assert property ( // RL2
    r.gsel[7:0] == 8'h02 && !r.gate_inv[0]
    |-> g[0] == r.sync2[int'(r.src_sel[2:0])])
    else $error("Gate 1 does not follow its selected source.");
  chk_empty_gate: assert property ( // RL5
    r.gsel[15:8] == 8'h00 |-> g[1] == r.gate_inv[1])
    else $error("Empty gate 2 differs from its polarity bit.");
  chk_and_mode: assert property ( // RL9
    r.en && r.mode == CLU_M_AND4
    |=> cell_out == ($past(&g) ^ $past(r.out_inv)))
    else $error("Four-input AND result is wrong.");
  chk_sr_set: assert property ( // RL10
    r.en && r.mode == CLU_M_SR && (g[0] || g[1]) |=> r.q)
    else $error("SR latch failed to set.");
  chk_jk_reset: assert property ( // RL12
    r.en && r.mode == CLU_M_JK && g[2] |=> !r.q ##1 !cell_out
    || $past(r.out_inv) || $past(r.mode) != CLU_M_JK)
    else $error("JK reset did not clear the cell.");
  chk_disabled_zero: assert property ( // RL16
    !r.en |=> !cell_out && !pin_oe)
    else $error("Disabled cell drives a nonzero output.");
  chk_rise_irq: assert property ( // RL17
    $rose(cell_out) && $past(r.rise_ie) |-> r.irq_stat[CLU_IRQ_RISE])
    else $error("Rising edge did not set its status bit.");
  chk_fall_irq: assert property ( // RL17
    $fell(cell_out) && $past(r.fall_ie) |-> r.irq_stat[CLU_IRQ_FALL])
    else $error("Falling edge did not set its status bit.");
  chk_irq_level: assert property ( // RL17
    irq == |(r.irq_stat & r.irq_mask))
    else $error("Interrupt line disagrees with masked status.");
  chk_or_xor: assert property ( // RL9
    r.en && r.mode == CLU_M_OR_XOR
    |=> cell_out == $past((g[0] | g[1]) ^ (g[2] | g[3]) ^ r.out_inv))
    else $error("Four-input OR-XOR result is wrong.");
  chk_sr_reset: assert property ( // RL10
    r.en && r.mode == CLU_M_SR && !(g[0] || g[1]) && (g[2] || g[3])
    |=> !r.q)
    else $error("SR latch failed to reset.");
  chk_dff_clock: assert property ( // RL10
    r.en && r.mode == CLU_M_DFF_SR && !g[2] && !g[3] && g_rise[0]
    |=> r.q == $past(g[1]))
    else $error("D flip-flop did not take its data on the clock.");
  chk_dff2_reset: assert property ( // RL11
    r.en && r.mode == CLU_M_DFF2 && g[2] |=> !r.q)
    else $error("Two-input flip-flop ignored its reset.");
  chk_latch_set: assert property ( // RL13
    r.en && r.mode == CLU_M_LATCH && !g[2] && g[3] |=> r.q)
    else $error("Transparent latch failed to set.");
  chk_pin_enable: assert property ( // RL18
    r.en && r.pin_de |=> pin_oe)
    else $error("Pin enable did not reach the pin.");
  chk_pin_gate: assert property ( // RL18
    !r.pin_de |=> !pin_out ##1 !pin_out || $past(r.pin_de))
    else $error("Pin driven while pin enable is clear.");
  chk_wait_one: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("Waitrequest held longer than one cycle.");

  // --------------------------------------------------------------
  // Cover points
  // --------------------------------------------------------------
  cov_jk_toggle: cover property (
    r.en && r.mode == CLU_M_JK ##1 $changed(cell_out));
  cov_irq: cover property ($rose(irq));
  cov_stat_read: cover property (rd && avs_address == CLU_ADDR_IRQ_STAT);
  cov_fall_irq: cover property (
    r.fall_ie && $fell(cell_out));
  cov_latch: cover property (r.en && r.mode == CLU_M_LATCH && g[0]);
endmodule // clu_cell
`default_nettype wire

// [logic/clu_pkg.sv]
/*
  Constants, register map and state type of the configurable logic unit.
  Assumes a 100 MHz system clock and an Avalon-MM master with 32-bit data.
*/
// Summary of operation
// RL1: Four input gates draw on a pool of 32 candidate signals via four muxes.
// RL2: Each source mux picks one of eight sources by its own select field.
// RL3: Each mux offers true and inverted outputs, eight gate terms in all.
// RL4: Each gate ORs the terms software enables for it.
// RL5: With no terms enabled a gate gives its polarity bit as a constant.
// RL6: Software selection bits route true or inverted mux outputs into each gate.
// RL7: Control holds enable, interrupt enables, pin enable, polarity and function.
// RL8: Output and each gate result have independent inversion settings.
// RL9: Codes 000, 001, 010 give AND-OR, OR-XOR and four-input AND.
// RL10: Code 011 is an SR latch; 100 a D flip-flop with set and reset.
// RL11: Code 101 is a two-input D flip-flop with reset.
// RL12: Code 110 is a JK flip-flop with reset.
// RL13: Code 111 is a transparent latch with set and reset.
// RL14: The cell output drives peripherals and a pin without software help.
// RL15: A set gate polarity bit inverts that gate result; clear passes it.
// RL16: While disabled the output is held at zero.
// RL17: Rising and falling output edges raise interrupts when enabled.
// RL18: A status bit shows the output level; pin enable gates the pin.
`default_nettype none
package clu_pkg;
  // --------------------------------------------------------------
  // Register map, byte addresses
  // --------------------------------------------------------------
  localparam logic [4:0] CLU_ADDR_CTRL_LOW = 5'h00;
  localparam logic [4:0] CLU_ADDR_CTRL_HIGH = 5'h04;
  localparam logic [4:0] CLU_ADDR_SRC_SEL = 5'h08;
  localparam logic [4:0] CLU_ADDR_GSEL_LOW = 5'h0C;
  localparam logic [4:0] CLU_ADDR_GSEL_HIGH = 5'h10;
  localparam logic [4:0] CLU_ADDR_IRQ_STAT = 5'h14;
  localparam logic [4:0] CLU_ADDR_IRQ_MASK = 5'h18;
  // --------------------------------------------------------------
  // Control low field positions, select field stride and interrupt status bits
  // --------------------------------------------------------------
  localparam int CLU_BIT_EN = 15;
  localparam int CLU_BIT_RISE_IE = 11;
  localparam int CLU_BIT_FALL_IE = 10;
  localparam int CLU_BIT_PIN_DE = 7;
  localparam int CLU_BIT_LEVEL = 6;
  localparam int CLU_BIT_OUT_INV = 5;
  localparam int CLU_SEL_STRIDE = 4;
  localparam int CLU_IRQ_RISE = 0;
  localparam int CLU_IRQ_FALL = 1;
  // --------------------------------------------------------------
  // Function codes
  // --------------------------------------------------------------
  localparam logic [2:0] CLU_M_AND_OR = 3'h0;
  localparam logic [2:0] CLU_M_OR_XOR = 3'h1;
  localparam logic [2:0] CLU_M_AND4 = 3'h2;
  localparam logic [2:0] CLU_M_SR = 3'h3;
  localparam logic [2:0] CLU_M_DFF_SR = 3'h4;
  localparam logic [2:0] CLU_M_DFF2 = 3'h5;
  localparam logic [2:0] CLU_M_JK = 3'h6;
  localparam logic [2:0] CLU_M_LATCH = 3'h7;
  // --------------------------------------------------------------
  // Module state
  // --------------------------------------------------------------
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic en;
    logic rise_ie;
    logic fall_ie;
    logic pin_de;
    logic out_inv;
    logic [2:0] mode;
    logic [3:0] gate_inv;
    logic [15:0] src_sel;
    logic [31:0] gsel;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic [31:0] sync1;
    logic [31:0] sync2;
    logic [3:0] gate_prev;
    logic q;
    logic out;
    logic irq;
    logic pin_out;
    logic pin_oe;
  } clu_state_t;
endpackage
`default_nettype wire

// [testbench/clu_src_model.sv]
/*
  Model of the peripherals and pins that feed the logic unit's sources.
  Assumes the bench picks the levels and the slot within each group of
  eight that carries them.
*/
`timescale 1ns/10ps
`default_nettype none
module clu_src_model (
  // Clock
  input wire logic clk_sys,
  // Levels to present and their slot
  input wire logic [3:0] d,
  input wire logic [2:0] pos,
  // Sources toward the cell
  output logic [31:0] src_in
);
  logic [7:0] noise = 8'h55;

  // Unused slots toggle every cycle, so a wrong mux pick cannot hold.
  always @(posedge clk_sys) noise <= ~noise;

  always_comb
  begin
    for (int k = 0; k < 4; k++)
    begin
      src_in[8*k +: 8] = noise;
      src_in[8*k + pos] = d[k];
    end
  end
endmodule // clu_src_model
`default_nettype wire

// [testbench/tb.sv]
/*
  Self-checking bench for the configurable logic unit.
  Assumes nothing of the bus latency; the watchdog bounds every wait.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module tb
  import clu_pkg::*;
;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [3:0] be = 4'h3;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [31:0] src_in;
  logic cell_out;
  logic pin_out;
  logic pin_oe;
  logic irq;
  logic [3:0] d = 4'h0;
  logic [2:0] pos = 3'h0;
  logic [31:0] rdv;
  int errors = 0;
  int n_checks = 0;
  // Row: mode, gate invert, {output invert, expected out}, source levels.
  logic [15:0] rows [35] = '{16'h0013, 16'h0005, 16'h0C10, 16'h1011,
    16'h1005, 16'h1035, 16'h201F, 16'h2007, 16'h2817, 16'h203E,
    16'h3011, 16'h3010, 16'h3004, 16'h3015, 16'h3011, 16'h6018,
    16'h6009, 16'h6002, 16'h6013, 16'h6004, 16'h5002, 16'h5013,
    16'h501B, 16'h501A, 16'h500B, 16'h7013, 16'h7010, 16'h7001,
    16'h7018, 16'h4010, 16'h4004, 16'h400C, 16'h4018, 16'h4010,
    16'h4001};

  always #5 clk_sys = ~clk_sys;

  clu_cell dut_u (.clk_sys(clk_sys), .reset(reset),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(be), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .src_in(src_in),
    .cell_out(cell_out), .pin_out(pin_out), .pin_oe(pin_oe), .irq(irq));

  clu_src_model src_u (.clk_sys(clk_sys), .d(d), .pos(pos),
    .src_in(src_in));

  task automatic bus(input logic wr, input logic [4:0] a,
    input logic [15:0] wd);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= {16'h0000, wd};
    // Only the watchdog ends a wait that never finishes.
    do
    begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    rdv = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rchk(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 16'h0000);
    `CHK("readdata", e, rdv)
  endtask

  task automatic settle(input logic [3:0] v);
    d <= v;
    repeat (6) @(posedge clk_sys);
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Watchdog
  // ------------------------------------------------------------
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    give_verdict();
  end

  initial
  begin
    repeat (8) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    `CHK("waitrequest", 1'b1, avs_waitrequest)
    `CHK("cell_out", 1'b0, cell_out)
    for (int i = 0; i < 8; i++)
      rchk(5'(i * 4), 32'h00000000);
    bus(1'b1, 5'h1C, 16'hFFFF);
    rchk(5'h1C, 32'h00000000);
    bus(1'b1, CLU_ADDR_CTRL_HIGH, 16'hFFFF);
    rchk(CLU_ADDR_CTRL_HIGH, 32'h0000000F);
    $display("test registers done");
    bus(1'b1, CLU_ADDR_GSEL_LOW, 16'h0802);
    bus(1'b1, CLU_ADDR_GSEL_HIGH, 16'h8020);
    for (int i = 0; i < 35; i++)
    begin
      bus(1'b1, CLU_ADDR_CTRL_HIGH, {12'h000, rows[i][11:8]});
      bus(1'b1, CLU_ADDR_CTRL_LOW,
        {8'h80, 2'b10, rows[i][5], 2'b00, rows[i][14:12]});
      settle(rows[i][3:0]);
      `CHK("cell_out", rows[i][4], cell_out)
      `CHK("pin_out", rows[i][4], pin_out)
      rchk(CLU_ADDR_CTRL_LOW, {16'h0000, 8'h80, 1'b1, rows[i][4],
        rows[i][5], 2'b00, rows[i][14:12]});
    end
    $display("test functions done");
    pos <= 3'h7;
    bus(1'b1, CLU_ADDR_SRC_SEL, 16'h7777);
    bus(1'b1, CLU_ADDR_GSEL_LOW, 16'h0401);
    bus(1'b1, CLU_ADDR_GSEL_HIGH, 16'h4010);
    bus(1'b1, CLU_ADDR_CTRL_HIGH, 16'h0000);
    bus(1'b1, CLU_ADDR_CTRL_LOW, 16'h8082);
    settle(4'h0);
    `CHK("cell_out", 1'b1, cell_out)
    settle(4'h1);
    `CHK("cell_out", 1'b0, cell_out)
    bus(1'b1, CLU_ADDR_GSEL_LOW, 16'h040A);
    settle(4'h1);
    `CHK("cell_out", 1'b1, cell_out)
    $display("test source select done");
    bus(1'b1, CLU_ADDR_GSEL_LOW, 16'h0000);
    bus(1'b1, CLU_ADDR_GSEL_HIGH, 16'h0000);
    bus(1'b1, CLU_ADDR_CTRL_HIGH, 16'h000F);
    settle(4'h0);
    `CHK("cell_out", 1'b1, cell_out)
    bus(1'b1, CLU_ADDR_CTRL_HIGH, 16'h0007);
    settle(4'hF);
    `CHK("cell_out", 1'b0, cell_out)
    bus(1'b1, CLU_ADDR_CTRL_HIGH, 16'h000F);
    bus(1'b1, CLU_ADDR_CTRL_LOW, 16'h0082);
    settle(4'h0);
    `CHK("cell_out", 1'b0, cell_out)
    `CHK("pin_oe", 1'b0, pin_oe)
    bus(1'b1, CLU_ADDR_CTRL_LOW, 16'h8082);
    settle(4'h0);
    `CHK("cell_out", 1'b1, cell_out)
    `CHK("pin_oe", 1'b1, pin_oe)
    $display("test constants and enable done");
    bus(1'b1, CLU_ADDR_IRQ_MASK, 16'h0001);
    bus(1'b1, CLU_ADDR_CTRL_HIGH, 16'h0000);
    settle(4'h0);
    bus(1'b1, CLU_ADDR_CTRL_LOW, 16'h8882);
    bus(1'b1, CLU_ADDR_CTRL_HIGH, 16'h000F);
    settle(4'h0);
    `CHK("irq", 1'b1, irq)
    rchk(CLU_ADDR_IRQ_STAT, 32'h00000001);
    settle(4'h0);
    `CHK("irq", 1'b0, irq)
    bus(1'b1, CLU_ADDR_CTRL_HIGH, 16'h0000);
    settle(4'h0);
    rchk(CLU_ADDR_IRQ_STAT, 32'h00000000);
    bus(1'b1, CLU_ADDR_CTRL_LOW, 16'h8482);
    bus(1'b1, CLU_ADDR_CTRL_HIGH, 16'h000F);
    settle(4'h0);
    bus(1'b1, CLU_ADDR_CTRL_HIGH, 16'h0000);
    settle(4'h0);
    `CHK("irq", 1'b0, irq)
    bus(1'b1, CLU_ADDR_IRQ_MASK, 16'h0003);
    settle(4'h0);
    `CHK("irq", 1'b1, irq)
    rchk(CLU_ADDR_IRQ_STAT, 32'h00000002);
    $display("test interrupts done");
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    `CHK("pin_oe", 1'b0, pin_oe)
    `CHK("waitrequest", 1'b1, avs_waitrequest)
    reset <= 1'b0;
    @(posedge clk_sys);
    rchk(CLU_ADDR_CTRL_LOW, 32'h00000000);
    rchk(CLU_ADDR_IRQ_MASK, 32'h00000000);
    be <= 4'h2;
    bus(1'b1, CLU_ADDR_SRC_SEL, 16'h7654);
    be <= 4'h3;
    rchk(CLU_ADDR_SRC_SEL, 32'h00007600);
    $display("test reset and lanes done");
    give_verdict();
  end
endmodule // tb
`default_nettype wire
